/* File: src/gtc_pkg.sv */
// constants shared by the general timer counter block
package gtc_pkg;
  // register byte addresses on the plain register port
  localparam logic [11:0] ADDR_COUNT_HI = 12'hf00;
  localparam logic [11:0] ADDR_COUNT_LO = 12'hf01;
  localparam logic [11:0] ADDR_RELOAD_HI = 12'hf02;
  localparam logic [11:0] ADDR_RELOAD_LO = 12'hf03;
  localparam logic [11:0] ADDR_CAPTURE_HI = 12'hf04;
  localparam logic [11:0] ADDR_CAPTURE_LO = 12'hf05;
  localparam logic [11:0] ADDR_CTL_LOW = 12'hf06;
  localparam logic [11:0] ADDR_CTL_HIGH = 12'hf07;
  localparam logic [11:0] ADDR_AUX = 12'hf08;

  // timer_control_low fields
  localparam int CTLL_MODE3_BIT = 7;
  localparam int CTLL_CAUSE_HI = 6;
  localparam int CTLL_CAUSE_LO = 5;
  localparam int CTLL_CASCADE_BIT = 4;
  localparam int CTLL_DEAD_HI = 3;
  localparam int CTLL_DEAD_LO = 1;
  localparam int CTLL_CAPFLAG_BIT = 0;

  // timer_control_high fields
  localparam int CTLH_EN_BIT = 7;
  localparam int CTLH_POL_BIT = 6;
  localparam int CTLH_PRE_HI = 5;
  localparam int CTLH_PRE_LO = 3;
  localparam int CTLH_MODE_HI = 2;
  localparam int CTLH_MODE_LO = 0;

  // auxiliary register fields
  localparam int AUX_COMPSEL_BIT = 0;
  localparam int AUX_OUTEN_BIT = 1;

  // values after reset, and the count start value loaded at reload
  localparam logic [7:0] CTL_LOW_RST = 8'h00;
  localparam logic [7:0] CTL_HIGH_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [15:0] CAPTURE_RST = 16'h0000;
  localparam logic [15:0] COUNT_START = 16'h0001;
  localparam logic [2:0] DEAD_RST = 3'h0;
  localparam logic [6:0] PRESCALE_CNT_RST = 7'h00;

  // operating_mode_select encodings
  localparam logic [3:0] MODE_CONTINUOUS = 4'h1;
  localparam logic [3:0] MODE_COUNTER = 4'h2;
  localparam logic [3:0] MODE_CAPTURE = 4'h4;
  localparam logic [3:0] MODE_COMP_COUNTER = 4'h9;

  // interrupt_cause_select encodings
  localparam logic [1:0] CAUSE_CAPTURE_ONLY = 2'b10;
  localparam logic [1:0] CAUSE_RELOAD_ONLY = 2'b11;
endpackage

/* File: src/gtc_sync.sv */
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module gtc_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic dataIn,
  output logic dataOut
);
  import gtc_pkg::*;

  logic stage1_r;
  logic stage1_nxt;
  logic stage2_r;
  logic stage2_nxt;

  always_comb begin
    stage1_nxt = dataIn;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign dataOut = stage2_r;

  a_sync_delay: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ##2 dataOut == $past(dataIn, 2))
    else $error("synchroniser output does not follow input two cycles later");
endmodule // gtc_sync

/* File: src/gtc_prescaler.sv */
// power-of-two clock prescaler giving a one-cycle count enable
`timescale 1ns/10ps
module gtc_prescaler (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic tickEn,
  input wire logic [2:0] prescale,
  output logic tick
);
  import gtc_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] mask;

  always_comb begin
    mask = ~(7'h7f << prescale);
    cnt_nxt = tickEn ? cnt_r + 7'h01 : PRESCALE_CNT_RST;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= PRESCALE_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // one pulse every 2^prescale cycles while enabled
  assign tick = tickEn && ((cnt_r & mask) == mask);
endmodule // gtc_prescaler

/* File: src/gtc_timer.sv */
// general timer counter: counter, comparator counter, capture and continuous modes
//
// Operation
// - pin counter mode advances count once per qualifying input transition
// - software start count holds only first pass; reloads restart at 0001H
// - comparator counter mode counts edges of the selected comparator output
// - polarity bit chooses rising or falling comparator edges
// - prescaler is bypassed in comparator counter mode
// - reaching reload raises interrupt, count returns to 0001H, counting continues
// - reload inverts timer output level when output function is enabled
// - control low bit 7 is mode MSB, other three bits in control high
// - cause field 0x all events, 10 capture only, 11 reload only
// - cascade bit takes input from preceding timer output instead of pin
// - control low bit 0 flags that last interrupt was a capture
// - control low holds deadband delay between complementary outputs
`timescale 1ns/10ps
module gtc_timer (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic timerInPin,
  input wire logic cascadeIn,
  input wire logic compAOut,
  input wire logic compBOut,
  output logic timerOut,
  output logic timerOutEn,
  output logic pwmHigh,
  output logic pwmLow,
  output logic timerIrq
);
  import gtc_pkg::*;

  // register state
  logic [7:0] ctlLow_r;
  logic [7:0] ctlLow_nxt;
  logic [7:0] ctlHigh_r;
  logic [7:0] ctlHigh_nxt;
  logic [7:0] aux_r;
  logic [7:0] aux_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] reload_r;
  logic [15:0] reload_nxt;
  logic [15:0] capture_r;
  logic [15:0] capture_nxt;

  // core state
  logic prevLvl_r;
  logic prevLvl_nxt;
  logic level_r;
  logic level_nxt;
  logic [2:0] deadCnt_r;
  logic [2:0] deadCnt_nxt;
  logic pwmHigh_r;
  logic pwmHigh_nxt;
  logic pwmLow_r;
  logic pwmLow_nxt;
  logic outEn_r;
  logic outEn_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;

  // decoded fields and events
  logic pinSync;
  logic compASync;
  logic compBSync;
  logic [3:0] opMode;
  logic [1:0] cause;
  logic [2:0] deadband;
  logic timerEn;
  logic edgePol;
  logic prescaleTick;
  logic prescaleRun;
  logic compSel;
  logic inputSel;
  logic srcLvl;
  logic edgeHit;
  logic countEvt;
  logic capEvt;
  logic reloadEvt;
  logic capIrq;
  logic reloadIrq;
  logic cntWr;

  gtc_sync u_pin_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .dataIn(timerInPin),
    .dataOut(pinSync)
  );

  gtc_sync u_comp_a_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .dataIn(compAOut),
    .dataOut(compASync)
  );

  gtc_sync u_comp_b_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .dataIn(compBOut),
    .dataOut(compBSync)
  );

  gtc_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tickEn(prescaleRun),
    .prescale(ctlHigh_r[CTLH_PRE_HI:CTLH_PRE_LO]),
    .tick(prescaleTick)
  );

  // mode selector spans both control registers
  assign opMode = {ctlLow_r[CTLL_MODE3_BIT], ctlHigh_r[CTLH_MODE_HI:CTLH_MODE_LO]};
  assign cause = ctlLow_r[CTLL_CAUSE_HI:CTLL_CAUSE_LO];
  assign deadband = ctlLow_r[CTLL_DEAD_HI:CTLL_DEAD_LO];
  assign timerEn = ctlHigh_r[CTLH_EN_BIT];
  assign edgePol = ctlHigh_r[CTLH_POL_BIT];

  // prescaler runs only for clock-driven modes
  assign prescaleRun = timerEn && ((opMode == MODE_CONTINUOUS) || (opMode == MODE_CAPTURE));

  // comparator assignment and cascade source selection
  assign compSel = aux_r[AUX_COMPSEL_BIT] ? compBSync : compASync;
  assign inputSel = ctlLow_r[CTLL_CASCADE_BIT] ? cascadeIn : pinSync;
  assign srcLvl = (opMode == MODE_COMP_COUNTER) ? compSel : inputSel;

  // edge found from current and previous sample, polarity 0 rising
  assign edgeHit = edgePol ? (!srcLvl && prevLvl_r) : (srcLvl && !prevLvl_r);

  // selected edges count directly in the edge modes
  assign countEvt = timerEn &&
    ((((opMode == MODE_COUNTER) || (opMode == MODE_COMP_COUNTER)) && edgeHit) ||
     (prescaleRun && prescaleTick));
  assign capEvt = timerEn && (opMode == MODE_CAPTURE) && edgeHit;
  assign reloadEvt = countEvt && (count_r == reload_r);

  // interrupt cause filtering
  assign capIrq = capEvt && (cause != CAUSE_RELOAD_ONLY);
  assign reloadIrq = reloadEvt && (cause != CAUSE_CAPTURE_ONLY);

  assign cntWr = regWrEn && ((regAddr == ADDR_COUNT_HI) || (regAddr == ADDR_COUNT_LO));

  always_comb begin
    ctlLow_nxt = ctlLow_r;
    ctlHigh_nxt = ctlHigh_r;
    aux_nxt = aux_r;
    count_nxt = count_r;
    reload_nxt = reload_r;
    capture_nxt = capture_r;
    prevLvl_nxt = srcLvl;
    level_nxt = level_r;
    deadCnt_nxt = deadCnt_r;
    outEn_nxt = aux_r[AUX_OUTEN_BIT];
    irq_nxt = capIrq || reloadIrq;

    // count step, reload restarts from the fixed start value
    if (countEvt) begin
      count_nxt = reloadEvt ? COUNT_START : count_r + 16'h0001;
    end
    if (capEvt) begin
      capture_nxt = count_r;
    end

    // output inversion at reload, deadband restarts on each change
    if (reloadEvt && aux_r[AUX_OUTEN_BIT]) begin
      level_nxt = !level_r;
      deadCnt_nxt = deadband;
    end else if (deadCnt_r != DEAD_RST) begin
      deadCnt_nxt = deadCnt_r - 3'h1;
    end

    // software writes; a direct count write overrides the step
    if (regWrEn) begin
      case (regAddr)
        ADDR_COUNT_HI: begin
          count_nxt[15:8] = regWrData;
        end
        ADDR_COUNT_LO: begin
          count_nxt[7:0] = regWrData;
        end
        ADDR_RELOAD_HI: begin
          reload_nxt[15:8] = regWrData;
        end
        ADDR_RELOAD_LO: begin
          reload_nxt[7:0] = regWrData;
        end
        ADDR_CTL_LOW: begin
          ctlLow_nxt = regWrData;
        end
        ADDR_CTL_HIGH: begin
          ctlHigh_nxt = regWrData;
        end
        ADDR_AUX: begin
          aux_nxt = {6'h00, regWrData[AUX_OUTEN_BIT], regWrData[AUX_COMPSEL_BIT]};
        end
        default: begin
        end
      endcase
    end

    // hardware flag update after the software write, so an event wins
    if (capIrq) begin
      ctlLow_nxt[CTLL_CAPFLAG_BIT] = 1'b1;
    end else if (reloadIrq) begin
      ctlLow_nxt[CTLL_CAPFLAG_BIT] = 1'b0;
    end

    // complementary pair, both low while the deadband runs
    pwmHigh_nxt = level_nxt && (deadCnt_nxt == DEAD_RST);
    pwmLow_nxt = !level_nxt && (deadCnt_nxt == DEAD_RST);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctlLow_r <= CTL_LOW_RST;
      ctlHigh_r <= CTL_HIGH_RST;
      aux_r <= AUX_RST;
      count_r <= COUNT_RST;
      reload_r <= RELOAD_RST;
      capture_r <= CAPTURE_RST;
      prevLvl_r <= 1'b0;
      level_r <= 1'b0;
      deadCnt_r <= DEAD_RST;
      pwmHigh_r <= 1'b0;
      pwmLow_r <= 1'b0;
      outEn_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctlLow_r <= ctlLow_nxt;
      ctlHigh_r <= ctlHigh_nxt;
      aux_r <= aux_nxt;
      count_r <= count_nxt;
      reload_r <= reload_nxt;
      capture_r <= capture_nxt;
      prevLvl_r <= prevLvl_nxt;
      level_r <= level_nxt;
      deadCnt_r <= deadCnt_nxt;
      pwmHigh_r <= pwmHigh_nxt;
      pwmLow_r <= pwmLow_nxt;
      outEn_r <= outEn_nxt;
      irq_r <= irq_nxt;
    end
  end

  // read data stands in the cycle after the strobe only
  always_comb begin
    rdData_nxt = 8'h00;
    if (regRdEn) begin
      case (regAddr)
        ADDR_COUNT_HI: rdData_nxt = count_r[15:8];
        ADDR_COUNT_LO: rdData_nxt = count_r[7:0];
        ADDR_RELOAD_HI: rdData_nxt = reload_r[15:8];
        ADDR_RELOAD_LO: rdData_nxt = reload_r[7:0];
        ADDR_CAPTURE_HI: rdData_nxt = capture_r[15:8];
        ADDR_CAPTURE_LO: rdData_nxt = capture_r[7:0];
        ADDR_CTL_LOW: rdData_nxt = ctlLow_r;
        ADDR_CTL_HIGH: rdData_nxt = ctlHigh_r;
        ADDR_AUX: rdData_nxt = aux_r;
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_r <= 8'h00;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign timerOut = level_r;
  assign timerOutEn = outEn_r;
  assign pwmHigh = pwmHigh_r;
  assign pwmLow = pwmLow_r;
  assign timerIrq = irq_r;

  a_count_step: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (countEvt && !reloadEvt && !cntWr) |=> (count_r == $past(count_r) + 16'h0001))
    else $error("count did not advance by one on a count event");

  a_reload_start: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reloadEvt && !cntWr) |=> (count_r == COUNT_START))
    else $error("count did not restart from the start value at reload");

  a_comp_counts: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (opMode == MODE_COMP_COUNTER && timerEn && edgeHit && !cntWr &&
     count_r != COUNT_START) |=> (count_r != $past(count_r)))
    else $error("comparator edge was not counted");

  a_polarity_skip: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (opMode == MODE_COMP_COUNTER && !edgePol && !srcLvl && prevLvl_r && !cntWr)
    |=> $stable(count_r))
    else $error("falling comparator edge counted while rising edges selected");

  a_prescale_bypass: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (opMode == MODE_COMP_COUNTER && !edgeHit && !cntWr) |=> $stable(count_r))
    else $error("count moved without a comparator edge");

  a_reload_irq: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reloadEvt && cause != CAUSE_CAPTURE_ONLY) |=> timerIrq ##1 !timerIrq || $past(countEvt))
    else $error("reload did not raise a one-cycle interrupt");

  a_out_toggle: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reloadEvt && aux_r[AUX_OUTEN_BIT]) |=> (timerOut != $past(timerOut)))
    else $error("timer output did not invert at reload");

  a_cause_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reloadEvt && cause == CAUSE_CAPTURE_ONLY && !capEvt) |=> !timerIrq)
    else $error("reload interrupt raised while capture-only cause selected");

  a_cascade_pick: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ctlLow_r[CTLL_CASCADE_BIT] && opMode == MODE_COUNTER && timerEn && !edgePol &&
     $stable(ctlLow_r) && $stable(opMode) && $rose(cascadeIn) && !cntWr &&
     count_r != reload_r) |=> (count_r == $past(count_r) + 16'h0001))
    else $error("cascade input edge was not counted");

  a_capture_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    capIrq |=> ctlLow_r[CTLL_CAPFLAG_BIT] && timerIrq)
    else $error("capture flag not set after capture interrupt");

  a_dead_gap: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (reloadEvt && aux_r[AUX_OUTEN_BIT] && deadband != DEAD_RST)
    |=> (!pwmHigh && !pwmLow) ##1 !(pwmHigh && pwmLow))
    else $error("complementary outputs not held off during deadband");
endmodule // gtc_timer

/* File: dv/gtc_edge_src.sv */
// behavioural source for the timer input pin and both comparator outputs
`timescale 1ns/10ps
module gtc_edge_src (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic startReq,
  input wire logic [1:0] chan,
  input wire logic [3:0] nToggles,
  output logic busy,
  output logic timerInPin,
  output logic compAOut,
  output logic compBOut
);
  logic [3:0] left_r;
  logic [2:0] hold_r;
  logic [1:0] chan_r;
  assign busy = (left_r != 4'h0) || (hold_r != 3'h0);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      left_r <= 4'h0;
      hold_r <= 3'h0;
      chan_r <= 2'd0;
      timerInPin <= 1'b0;
      compAOut <= 1'b0;
      compBOut <= 1'b0;
    end else if (startReq) begin
      left_r <= nToggles;
      chan_r <= chan;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
      // each level stands four clocks so no edge is lost
      hold_r <= 3'h3;
      case (chan_r)
        2'd0: timerInPin <= ~timerInPin;
        2'd1: compAOut <= ~compAOut;
        default: compBOut <= ~compBOut;
      endcase
    end
  end
endmodule // gtc_edge_src

/* File: dv/general_timer_counter_modes_bench.sv */
// self-checking bench for the general timer counter
`timescale 1ns/10ps
module general_timer_counter_modes_bench;
  import gtc_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic cascadeIn = 1'b0;
  logic startReq = 1'b0;
  logic [1:0] chan = 2'd0;
  logic [3:0] nToggles = 4'h0;
  logic busy, timerInPin, compAOut, compBOut;
  logic timerOut, timerOutEn, pwmHigh, pwmLow, timerIrq;
  logic [15:0] irqCnt = 16'h0000;
  logic [15:0] gapCnt = 16'h0000;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  gtc_timer gtc_timer_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .timerInPin(timerInPin), .cascadeIn(cascadeIn), .compAOut(compAOut),
    .compBOut(compBOut), .timerOut(timerOut), .timerOutEn(timerOutEn),
    .pwmHigh(pwmHigh), .pwmLow(pwmLow), .timerIrq(timerIrq)
  );
  gtc_edge_src gtc_edge_src_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .startReq(startReq), .chan(chan),
    .nToggles(nToggles), .busy(busy), .timerInPin(timerInPin),
    .compAOut(compAOut), .compBOut(compBOut)
  );

  always @(posedge sys_clk) begin
    if (timerIrq === 1'b1) begin
      irqCnt <= irqCnt + 16'h0001;
    end
    // cycles with both pwm outputs off
    if (pwmHigh === 1'b0 && pwmLow === 1'b0) begin
      gapCnt <= gapCnt + 16'h0001;
    end
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // strobes drop for one cycle between accesses so no signal is set twice per step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
    @(posedge sys_clk);
  endtask

  task automatic wr16(input logic [11:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 12'h001, v[7:0]);
  endtask

  task automatic rdCount(output logic [15:0] c);
    rd(ADDR_COUNT_HI, c[15:8]);
    rd(ADDR_COUNT_LO, c[7:0]);
  endtask

  task automatic cnt(input logic [15:0] exp);
    logic [15:0] c;
    rdCount(c);
    chk(c, exp);
  endtask

  // run n level changes on one source, then let the synchroniser settle
  task automatic go(input logic [1:0] ch, input logic [3:0] n);
    chan <= ch;
    nToggles <= n;
    startReq <= 1'b1;
    @(posedge sys_clk);
    startReq <= 1'b0;
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      #1;
      if (busy !== 1'b1) break;
    end
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic tRegs();
    logic [11:0] a [6] = '{ADDR_CTL_LOW, ADDR_CTL_HIGH, ADDR_AUX, ADDR_RELOAD_HI,
                           ADDR_COUNT_LO, 12'hf09};
    logic [7:0] e [6] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(a[i], d);
      chk({8'h00, d}, {8'h00, e[i]});
    end
    chk({14'h0000, pwmHigh, pwmLow}, 16'h0001);
    wr(ADDR_CTL_LOW, 8'h1e);
    rd(ADDR_CTL_LOW, d);
    chk({8'h00, d}, 16'h001e);
    wr(12'hf09, 8'h55);
    rd(12'hf09, d);
    chk({8'h00, d}, 16'h0000);
  endtask

  task automatic tCounter();
    logic [15:0] base;
    wr(ADDR_CTL_LOW, 8'h00);
    wr16(ADDR_COUNT_HI, 16'h0003);
    wr16(ADDR_RELOAD_HI, 16'h0004);
    wr(ADDR_AUX, 8'h02);
    wr(ADDR_CTL_HIGH, 8'h82);
    chk({15'h0000, timerOutEn}, 16'h0001);
    go(2'd0, 4'h2);
    cnt(16'h0004);
    base = irqCnt;
    go(2'd0, 4'h2);
    cnt(16'h0001);
    chk(irqCnt - base, 16'h0001);
    chk({15'h0000, timerOut}, 16'h0001);
    go(2'd0, 4'h6);
    cnt(16'h0004);
    go(2'd0, 4'h2);
    chk(irqCnt - base, 16'h0002);
    chk({15'h0000, timerOut}, 16'h0000);
  endtask

  task automatic tCause();
    logic [15:0] base;
    logic [15:0] ex [4] = '{16'h0001, 16'h0001, 16'h0000, 16'h0001};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTL_LOW, {1'b0, 2'(i), 5'h00});
      wr16(ADDR_COUNT_HI, 16'h0004);
      base = irqCnt;
      go(2'd0, 4'h2);
      chk(irqCnt - base, ex[i]);
    end
  endtask

  task automatic tCapture();
    logic [7:0] d;
    logic [15:0] base;
    wr(ADDR_CTL_HIGH, 8'h00);
    wr(ADDR_CTL_LOW, 8'h00);
    wr16(ADDR_RELOAD_HI, 16'hffff);
    wr(ADDR_CTL_HIGH, 8'h84);
    base = irqCnt;
    go(2'd0, 4'h2);
    rd(ADDR_CTL_LOW, d);
    chk({15'h0000, d[0]}, 16'h0001);
    chk(irqCnt - base, 16'h0001);
    // reload-only cause: a capture raises nothing and leaves the flag clear
    wr(ADDR_CTL_LOW, 8'h60);
    base = irqCnt;
    go(2'd0, 4'h2);
    chk(irqCnt - base, 16'h0000);
    rd(ADDR_CTL_LOW, d);
    chk({8'h00, d}, 16'h0060);
  endtask

  // deadband of three holds both pwm outputs off for three cycles at the inversion
  task automatic tDead();
    logic [15:0] base;
    logic h0;
    wr(ADDR_CTL_HIGH, 8'h00);
    wr(ADDR_CTL_LOW, 8'h06);
    wr(ADDR_AUX, 8'h02);
    wr16(ADDR_COUNT_HI, 16'h0001);
    wr16(ADDR_RELOAD_HI, 16'h0001);
    wr(ADDR_CTL_HIGH, 8'h82);
    chk({15'h0000, pwmHigh ^ pwmLow}, 16'h0001);
    h0 = pwmHigh;
    base = gapCnt;
    go(2'd0, 4'h2);
    chk(gapCnt - base, 16'h0003);
    chk({15'h0000, pwmHigh}, {15'h0000, !h0});
  endtask

  // continuous mode, divide by two: eleven ticks while enabled for 22 cycles
  task automatic tCont();
    wr(ADDR_CTL_HIGH, 8'h00);
    wr16(ADDR_COUNT_HI, 16'h0001);
    wr16(ADDR_RELOAD_HI, 16'hffff);
    wr(ADDR_CTL_HIGH, 8'h89);
    repeat (20) @(posedge sys_clk);
    wr(ADDR_CTL_HIGH, 8'h09);
    cnt(16'h000c);
  endtask

  task automatic tComp();
    logic [15:0] c0;
    wr(ADDR_CTL_HIGH, 8'h00);
    wr(ADDR_CTL_LOW, 8'h80);
    wr16(ADDR_COUNT_HI, 16'h0001);
    wr(ADDR_AUX, 8'h01);
    // slowest prescale: any count seen here proves the bypass
    wr(ADDR_CTL_HIGH, 8'hb9);
    rdCount(c0);
    go(2'd1, 4'h4);
    cnt(c0);
    go(2'd2, 4'h2);
    cnt(c0 + 16'h0001);
    wr(ADDR_CTL_HIGH, 8'h79);
    wr(ADDR_CTL_HIGH, 8'hf9);
    rdCount(c0);
    go(2'd2, 4'h1);
    cnt(c0);
    go(2'd2, 4'h1);
    cnt(c0 + 16'h0001);
  endtask

  task automatic tCascade();
    logic [15:0] c0;
    wr(ADDR_CTL_HIGH, 8'h00);
    wr(ADDR_CTL_LOW, 8'h10);
    wr(ADDR_CTL_HIGH, 8'h82);
    rdCount(c0);
    go(2'd0, 4'h2);
    cnt(c0);
    cascadeIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cascadeIn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cnt(c0 + 16'h0001);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    tRegs();
    tCounter();
    tCause();
    tCapture();
    tComp();
    tCascade();
    tDead();
    tCont();
    test_done();
  end
endmodule // general_timer_counter_modes_bench
